/* File: design/mrrx_pkg.sv */
// package: constants, opcodes and carriers for the move/return/rotate execution block
package mrrx_pkg;

    // apb register byte offsets
    localparam logic [11:0] MRRX_CMD_OFF = 12'h000;
    localparam logic [11:0] MRRX_STATUS_OFF = 12'h004;
    localparam logic [11:0] MRRX_PC_OFF = 12'h008;
    localparam logic [11:0] MRRX_STACK_OFF = 12'h00c;
    localparam logic [11:0] MRRX_FILE_BASE = 12'h100;
    localparam logic [11:0] MRRX_FILE_LAST = 12'h2fc;

    // widths
    localparam int unsigned MRRX_PC_W = 11;
    localparam int unsigned MRRX_LEVEL_W = 4;
    localparam int unsigned MRRX_FILE_AW = 7;

    // status register field positions
    localparam int unsigned MRRX_STAT_Z_BIT = 8;
    localparam int unsigned MRRX_STAT_C_BIT = 9;
    localparam int unsigned MRRX_STAT_GIE_BIT = 10;

    // values after reset
    localparam logic [7:0] MRRX_WORK_RESET = 8'h00;
    localparam logic [10:0] MRRX_PC_RESET = 11'h000;
    localparam logic [3:0] MRRX_LEVEL_RESET = 4'h0;

    // instruction cycle counts, less one
    localparam logic MRRX_EXTRA_SINGLE = 1'b0;
    localparam logic MRRX_EXTRA_RETURN = 1'b1;

    typedef enum logic [2:0] {
        MRRX_OP_NOP = 3'b000,
        MRRX_OP_WORK_TO_FILE_MOVE = 3'b001,
        MRRX_OP_LITERAL_TO_WORK_LOAD = 3'b010,
        MRRX_OP_FILE_REGISTER_MOVE = 3'b011,
        MRRX_OP_INTERRUPT_RETURN_ENABLE = 3'b100,
        MRRX_OP_LITERAL_RETURN = 3'b101,
        MRRX_OP_ROTATE_LEFT_THROUGH_CARRY = 3'b110
    } mrrx_op_type;

    // command word: operand [11:4], destination select [3], opcode [2:0]
    typedef struct packed {
        logic [7:0] operand;
        logic dest;
        mrrx_op_type op;
    } mrrx_cmd_type;

    typedef struct packed {
        logic global_interrupt_enable;
        logic c;
        logic z;
    } mrrx_flags_type;

endpackage

/* File: design/mrrx_exec.sv */
// execution unit for moves, no-operation, stack returns and rotate-left through carry
//
// Functional notes
// RULE_01: work_to_file_move copies work into file register 0..127; no flags, one cycle.
// RULE_02: literal_to_work_load puts the 8-bit literal in work; no flags, one cycle.
// RULE_03: the no-operation only advances the program counter by one and takes one cycle.
// RULE_04: file_register_move writes work for dest 0 or the file for dest 1, in one cycle.
// RULE_05: file_register_move sets the zero flag from the moved value for either destination.
// RULE_06: interrupt_return_enable pops pc and sets global_interrupt_enable, two cycles.
// RULE_07: an interrupt_return_enable at stack level 2 takes entry 2 and leaves the level at 1.
// RULE_08: literal_return loads the literal into work and pops pc, two cycles.
// RULE_09: rotate_left_through_carry moves carry into bit 0, bits 6..0 up, bit 7 to carry.
// RULE_10: rotate_left_through_carry writes work or file by dest, changes only carry, 1 cycle.
// RULE_11: single-cycle ops advance pc by one; returns take pc only from the stack.
`timescale 1ns/1ps
`default_nettype none

module mrrx_exec
    import mrrx_pkg::*;
#(
    parameter int unsigned STACK_DEPTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // architectural state
    logic [7:0] work_register;
    mrrx_flags_type flags;
    logic [10:0] pc;
    logic [3:0] level;
    logic [7:0] file_mem [128];
    logic [10:0] stack_mem [STACK_DEPTH];

    // command sequencing
    mrrx_cmd_type cmd_q;
    logic busy;
    logic extra;
    logic rd_ready;

    // apb decode
    wire logic hit_cmd = (paddr == MRRX_CMD_OFF);
    wire logic hit_status = (paddr == MRRX_STATUS_OFF);
    wire logic hit_pc = (paddr == MRRX_PC_OFF);
    wire logic hit_stack = (paddr == MRRX_STACK_OFF);
    wire logic hit_file = (paddr >= MRRX_FILE_BASE) && (paddr <= MRRX_FILE_LAST)
        && (paddr[1:0] == 2'b00);
    wire logic hit_any = hit_cmd | hit_status | hit_pc | hit_stack | hit_file;
    wire logic [11:0] file_off = paddr - MRRX_FILE_BASE;
    wire logic [6:0] bus_file_idx = file_off[8:2];
    wire logic xfer_done = psel & penable & rd_ready;
    wire logic bus_wr = xfer_done & pwrite & (pstrb != 4'h0);
    wire mrrx_cmd_type wr_cmd = mrrx_cmd_type'(pwdata[11:0]);
    wire logic accept = bus_wr & hit_cmd;
    wire logic wr_return = (wr_cmd.op == MRRX_OP_INTERRUPT_RETURN_ENABLE)
        || (wr_cmd.op == MRRX_OP_LITERAL_RETURN);
    wire logic exec_fire = busy & (extra == 1'b0);

    // operand fetch and stack top
    wire logic [6:0] exec_idx = cmd_q.operand[6:0];
    wire logic [7:0] file_rd = file_mem[exec_idx];
    wire logic level_nz = (level != 4'h0);
    wire logic [3:0] top_idx = level_nz ? level - 4'h1 : 4'h0;
    wire logic [10:0] top_entry = stack_mem[top_idx[$clog2(STACK_DEPTH)-1:0]];
    wire logic [7:0] rot = {file_rd[6:0], flags.c}; // RULE_09
    wire logic stack_full = (32'(level) >= STACK_DEPTH);

    // read mux
    wire logic [31:0] rd_status = {16'h0000, level, busy, flags, work_register};
    wire logic [31:0] rd_pc = {21'h000000, pc};
    wire logic [31:0] rd_stack = {16'h0000, level, 1'b0, top_entry};
    wire logic [31:0] rd_cmd = {20'h00000, cmd_q};
    wire logic [31:0] rd_file = {24'h000000, file_mem[bus_file_idx]};
    wire logic [31:0] rd_mux = hit_cmd ? rd_cmd :
        hit_status ? rd_status :
        hit_pc ? rd_pc :
        hit_stack ? rd_stack :
        hit_file ? rd_file : 32'h00000000;

    assign pready = rd_ready;
    assign pslverr = rd_ready & ~hit_any;

    // execution results
    logic [7:0] next_work;
    mrrx_flags_type next_flags;
    logic [10:0] next_pc;
    logic [3:0] next_level;
    logic exec_we;
    logic [7:0] exec_wd;

    always_comb begin
        next_work = work_register;
        next_flags = flags;
        next_pc = pc + 11'h001; // RULE_11
        next_level = level;
        exec_we = 1'b0;
        exec_wd = work_register;
        unique case (cmd_q.op)
            MRRX_OP_NOP: begin
                next_work = work_register; // RULE_03
            end
            MRRX_OP_WORK_TO_FILE_MOVE: begin
                exec_we = 1'b1; // RULE_01
                exec_wd = work_register;
            end
            MRRX_OP_LITERAL_TO_WORK_LOAD: begin
                next_work = cmd_q.operand; // RULE_02
            end
            MRRX_OP_FILE_REGISTER_MOVE: begin
                next_flags.z = (file_rd == 8'h00); // RULE_05
                exec_we = cmd_q.dest; // RULE_04
                exec_wd = file_rd;
                if (!cmd_q.dest) begin
                    next_work = file_rd; // RULE_04
                end
            end
            MRRX_OP_INTERRUPT_RETURN_ENABLE: begin
                next_pc = top_entry; // RULE_06
                next_flags.global_interrupt_enable = 1'b1; // RULE_06
                next_level = level_nz ? level - 4'h1 : level; // RULE_07
            end
            MRRX_OP_LITERAL_RETURN: begin
                next_work = cmd_q.operand; // RULE_08
                next_pc = top_entry; // RULE_08
                next_level = level_nz ? level - 4'h1 : level; // RULE_08
            end
            MRRX_OP_ROTATE_LEFT_THROUGH_CARRY: begin
                next_flags.c = file_rd[7]; // RULE_09
                exec_we = cmd_q.dest; // RULE_10
                exec_wd = rot;
                if (!cmd_q.dest) begin
                    next_work = rot; // RULE_10
                end
            end
            default: begin
                // illegal opcode retires without effect
                next_pc = pc;
            end
        endcase
    end

    // apb wait state: read data is captured on the same edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ready <= 1'b0;
            prdata <= 32'h00000000;
        end else if (xfer_done) begin
            rd_ready <= 1'b0;
        end else if (psel && penable && !busy) begin
            rd_ready <= 1'b1;
            prdata <= pwrite ? 32'h00000000 : rd_mux;
        end
    end

    // command acceptance and cycle counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q <= '0;
            busy <= 1'b0;
            extra <= 1'b0;
        end else if (accept) begin
            cmd_q <= wr_cmd;
            busy <= 1'b1;
            extra <= wr_return ? MRRX_EXTRA_RETURN : MRRX_EXTRA_SINGLE; // RULE_06
        end else if (exec_fire) begin
            busy <= 1'b0;
        end else if (busy) begin
            extra <= 1'b0;
        end
    end

    // work register, flags, program counter and stack level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            work_register <= MRRX_WORK_RESET;
            flags <= '0;
            pc <= MRRX_PC_RESET;
            level <= MRRX_LEVEL_RESET;
        end else if (exec_fire) begin
            work_register <= next_work;
            flags <= next_flags;
            pc <= next_pc;
            level <= next_level;
        end else if (bus_wr && hit_status) begin
            flags.z <= pwdata[MRRX_STAT_Z_BIT];
            flags.c <= pwdata[MRRX_STAT_C_BIT];
            flags.global_interrupt_enable <= pwdata[MRRX_STAT_GIE_BIT];
        end else if (bus_wr && hit_pc) begin
            pc <= pwdata[10:0];
        end else if (bus_wr && hit_stack && !stack_full) begin
            level <= level + 4'h1;
        end
    end

    // stack entries are pushed by software in place of a call
    always_ff @(posedge pclk) begin
        if (bus_wr && hit_stack && !stack_full) begin
            stack_mem[level[$clog2(STACK_DEPTH)-1:0]] <= pwdata[10:0];
        end
    end

    // file registers, written by execution or by the bus
    always_ff @(posedge pclk) begin
        if (exec_fire && exec_we) begin
            file_mem[exec_idx] <= exec_wd; // RULE_01
        end else if (bus_wr && hit_file) begin
            file_mem[bus_file_idx] <= pwdata[7:0];
        end
    end

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_work_to_file;
        exec_fire && cmd_q.op == MRRX_OP_WORK_TO_FILE_MOVE |=>
            file_mem[$past(exec_idx)] == $past(work_register) && flags == $past(flags);
    endproperty
    a_work_to_file: assert property (p_work_to_file) // RULE_01
        else $error("work register not copied to file register");

    property p_literal_load;
        exec_fire && cmd_q.op == MRRX_OP_LITERAL_TO_WORK_LOAD |=>
            work_register == $past(cmd_q.operand) && flags == $past(flags);
    endproperty
    a_literal_load: assert property (p_literal_load) // RULE_02
        else $error("literal not loaded into work register");

    property p_nop;
        exec_fire && cmd_q.op == MRRX_OP_NOP |=>
            pc == $past(pc) + 11'h001 && work_register == $past(work_register)
            && flags == $past(flags) && level == $past(level);
    endproperty
    a_nop: assert property (p_nop) // RULE_03
        else $error("no-operation changed state");

    property p_file_move_dest;
        exec_fire && cmd_q.op == MRRX_OP_FILE_REGISTER_MOVE |=>
            ($past(cmd_q.dest) ? (work_register == $past(work_register)
            && file_mem[$past(exec_idx)] == $past(file_rd))
            : work_register == $past(file_rd));
    endproperty
    a_file_move_dest: assert property (p_file_move_dest) // RULE_04
        else $error("file move went to wrong destination");

    property p_file_move_zero;
        exec_fire && cmd_q.op == MRRX_OP_FILE_REGISTER_MOVE |=>
            flags.z == ($past(file_rd) == 8'h00) && flags.c == $past(flags.c);
    endproperty
    a_file_move_zero: assert property (p_file_move_zero) // RULE_05
        else $error("zero flag wrong after file move");

    property p_interrupt_return;
        exec_fire && cmd_q.op == MRRX_OP_INTERRUPT_RETURN_ENABLE && level_nz |=>
            flags.global_interrupt_enable && pc == $past(top_entry) && level == $past(level) - 4'h1;
    endproperty
    a_interrupt_return: assert property (p_interrupt_return) // RULE_06
        else $error("interrupt return did not pop and enable");

    property p_return_two_cycles;
        accept && wr_return |=> busy && !exec_fire ##1 exec_fire ##1 !busy;
    endproperty
    a_return_two_cycles: assert property (p_return_two_cycles) // RULE_08
        else $error("return did not take two cycles");

    property p_level_two;
        exec_fire && cmd_q.op == MRRX_OP_INTERRUPT_RETURN_ENABLE && level == 4'h2 |=>
            level == 4'h1 && pc == $past(stack_mem[1]);
    endproperty
    a_level_two: assert property (p_level_two) // RULE_07
        else $error("return at level 2 did not use entry 2");

    property p_literal_return;
        exec_fire && cmd_q.op == MRRX_OP_LITERAL_RETURN && level_nz |=>
            work_register == $past(cmd_q.operand) && pc == $past(top_entry)
            && level == $past(level) - 4'h1;
    endproperty
    a_literal_return: assert property (p_literal_return) // RULE_08
        else $error("literal return wrong");

    property p_rotate_carry;
        exec_fire && cmd_q.op == MRRX_OP_ROTATE_LEFT_THROUGH_CARRY |=>
            flags.c == $past(file_rd[7]) && flags.z == $past(flags.z)
            && flags.global_interrupt_enable == $past(flags.global_interrupt_enable);
    endproperty
    a_rotate_carry: assert property (p_rotate_carry) // RULE_09
        else $error("rotate carry wrong");

    property p_rotate_dest;
        exec_fire && cmd_q.op == MRRX_OP_ROTATE_LEFT_THROUGH_CARRY |=>
            ($past(cmd_q.dest) ? file_mem[$past(exec_idx)] == {$past(file_rd[6:0]),
            $past(flags.c)} : work_register == {$past(file_rd[6:0]), $past(flags.c)});
    endproperty
    a_rotate_dest: assert property (p_rotate_dest) // RULE_10
        else $error("rotate result misplaced");

    property p_single_cycle;
        accept && !wr_return && wr_cmd.op != 3'b111 |=> exec_fire ##1 pc == $past(pc) + 11'h001;
    endproperty
    a_single_cycle: assert property (p_single_cycle) // RULE_11
        else $error("single-cycle instruction did not advance pc");

    property p_rotate_keeps_work;
        exec_fire && cmd_q.op == MRRX_OP_ROTATE_LEFT_THROUGH_CARRY && cmd_q.dest |=>
            work_register == $past(work_register);
    endproperty
    a_rotate_keeps_work: assert property (p_rotate_keeps_work) // RULE_10
        else $error("rotate into file changed work register");

    property p_interrupt_return_keeps;
        exec_fire && cmd_q.op == MRRX_OP_INTERRUPT_RETURN_ENABLE |=>
            work_register == $past(work_register) && flags.z == $past(flags.z)
            && flags.c == $past(flags.c);
    endproperty
    a_interrupt_return_keeps: assert property (p_interrupt_return_keeps) // RULE_06
        else $error("interrupt return changed work register or flags");

    property p_literal_return_flags;
        exec_fire && cmd_q.op == MRRX_OP_LITERAL_RETURN |=> flags == $past(flags);
    endproperty
    a_literal_return_flags: assert property (p_literal_return_flags) // RULE_08
        else $error("literal return changed flags");

    // an illegal opcode retires without touching pc or any state
    property p_illegal_inert;
        exec_fire && cmd_q.op == 3'b111 |=> pc == $past(pc) && level == $past(level)
            && work_register == $past(work_register) && flags == $past(flags);
    endproperty
    a_illegal_inert: assert property (p_illegal_inert) // RULE_11
        else $error("illegal opcode had an effect");

    c_return_level_two: cover property (exec_fire
        && cmd_q.op == MRRX_OP_INTERRUPT_RETURN_ENABLE && level == 4'h2);
    c_rotate_to_file: cover property (exec_fire
        && cmd_q.op == MRRX_OP_ROTATE_LEFT_THROUGH_CARRY && cmd_q.dest);
    c_zero_test: cover property (exec_fire
        && cmd_q.op == MRRX_OP_FILE_REGISTER_MOVE && cmd_q.dest && file_rd == 8'h00);
    c_literal_return: cover property (exec_fire && cmd_q.op == MRRX_OP_LITERAL_RETURN);

endmodule

`default_nettype wire

/* File: testbench/mrrx_testbench.sv */
// self-checking bench for the move, return and rotate execution unit
`timescale 1ns/1ps
`default_nettype none

module testbench
    import mrrx_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    mrrx_exec #(.STACK_DEPTH(8)) u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // the whole run needs well under a thousand cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task automatic rdchk(input string what, input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(what, rd, exp);
    endtask

    task automatic exec(input mrrx_op_type op, input logic dest, input logic [7:0] operand);
        mrrx_cmd_type cmd;
        cmd = '{operand: operand, dest: dest, op: op};
        wr(MRRX_CMD_OFF, {20'h00000, cmd});
    endtask

    function automatic logic [11:0] fa(input logic [6:0] n);
        return MRRX_FILE_BASE + {3'h0, n, 2'b00};
    endfunction

    function automatic logic [31:0] st(input logic [7:0] work, input logic z, input logic c,
                                       input logic ien, input logic [3:0] lvl);
        return {16'h0000, lvl, 1'b0, ien, c, z, work};
    endfunction

    task automatic t_reset();
        rdchk("status after reset", MRRX_STATUS_OFF, st(8'h00, 1'b0, 1'b0, 1'b0, 4'h0));
        rdchk("pc after reset", MRRX_PC_OFF, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        check("unmapped data", rd, 32'h0000_0000);
    endtask

    task automatic t_load_store_nop();
        wr(MRRX_STATUS_OFF, st(8'h00, 1'b1, 1'b1, 1'b0, 4'h0));
        wr(MRRX_PC_OFF, 32'h0000_0010);
        exec(MRRX_OP_LITERAL_TO_WORK_LOAD, 1'b0, 8'ha5);
        rdchk("load status", MRRX_STATUS_OFF, st(8'ha5, 1'b1, 1'b1, 1'b0, 4'h0));
        rdchk("load pc", MRRX_PC_OFF, 32'h0000_0011);
        exec(MRRX_OP_WORK_TO_FILE_MOVE, 1'b0, 8'h7f);
        rdchk("store file", fa(7'h7f), 32'h0000_00a5);
        rdchk("store status", MRRX_STATUS_OFF, st(8'ha5, 1'b1, 1'b1, 1'b0, 4'h0));
        rdchk("store pc", MRRX_PC_OFF, 32'h0000_0012);
        exec(MRRX_OP_NOP, 1'b0, 8'h00);
        rdchk("nop status", MRRX_STATUS_OFF, st(8'ha5, 1'b1, 1'b1, 1'b0, 4'h0));
        rdchk("nop file", fa(7'h7f), 32'h0000_00a5);
        rdchk("nop pc", MRRX_PC_OFF, 32'h0000_0013);
    endtask

    task automatic t_move();
        wr(fa(7'h05), 32'h0000_0000);
        wr(MRRX_STATUS_OFF, st(8'h00, 1'b0, 1'b1, 1'b0, 4'h0));
        exec(MRRX_OP_FILE_REGISTER_MOVE, 1'b0, 8'h05);
        rdchk("to work", MRRX_STATUS_OFF, st(8'h00, 1'b1, 1'b1, 1'b0, 4'h0));
        wr(fa(7'h06), 32'h0000_0080);
        exec(MRRX_OP_FILE_REGISTER_MOVE, 1'b1, 8'h06);
        rdchk("move back status", MRRX_STATUS_OFF, st(8'h00, 1'b0, 1'b1, 1'b0, 4'h0));
        rdchk("move back file", fa(7'h06), 32'h0000_0080);
        rdchk("move pc", MRRX_PC_OFF, 32'h0000_0015);
    endtask

    task automatic t_rotate();
        wr(fa(7'h03), 32'h0000_00a5);
        wr(MRRX_STATUS_OFF, st(8'h00, 1'b1, 1'b0, 1'b0, 4'h0));
        exec(MRRX_OP_ROTATE_LEFT_THROUGH_CARRY, 1'b1, 8'h03);
        rdchk("rotate file", fa(7'h03), 32'h0000_004a);
        rdchk("rotate flags", MRRX_STATUS_OFF, st(8'h00, 1'b1, 1'b1, 1'b0, 4'h0));
        exec(MRRX_OP_ROTATE_LEFT_THROUGH_CARRY, 1'b0, 8'h03);
        rdchk("rotate work", MRRX_STATUS_OFF, st(8'h95, 1'b1, 1'b0, 1'b0, 4'h0));
        rdchk("rotate keeps file", fa(7'h03), 32'h0000_004a);
        rdchk("rotate pc", MRRX_PC_OFF, 32'h0000_0017);
    endtask

    task automatic t_return();
        wr(MRRX_PC_OFF, 32'h0000_0123);
        wr(MRRX_STACK_OFF, 32'h0000_0111);
        wr(MRRX_STACK_OFF, 32'h0000_0222);
        rdchk("level two", MRRX_STATUS_OFF, st(8'h95, 1'b1, 1'b0, 1'b0, 4'h2));
        rdchk("stack top", MRRX_STACK_OFF, 32'h0000_2222);
        exec(MRRX_OP_INTERRUPT_RETURN_ENABLE, 1'b0, 8'h00);
        rdchk("int return pc", MRRX_PC_OFF, 32'h0000_0222);
        rdchk("int return status", MRRX_STATUS_OFF, st(8'h95, 1'b1, 1'b0, 1'b1, 4'h1));
        exec(MRRX_OP_LITERAL_RETURN, 1'b0, 8'h3c);
        rdchk("lit return pc", MRRX_PC_OFF, 32'h0000_0111);
        rdchk("lit return status", MRRX_STATUS_OFF, st(8'h3c, 1'b1, 1'b0, 1'b1, 4'h0));
    endtask

    // illegal opcode, a write with no byte strobes, and a push onto a full stack
    task automatic t_refused();
        exec(mrrx_op_type'(3'h7), 1'b0, 8'h00);
        rdchk("illegal pc", MRRX_PC_OFF, 32'h0000_0111);
        rdchk("illegal status", MRRX_STATUS_OFF, st(8'h3c, 1'b1, 1'b0, 1'b1, 4'h0));
        pstrb <= 4'h0;
        wr(fa(7'h03), 32'h0000_0011);
        pstrb <= 4'hf;
        rdchk("masked write", fa(7'h03), 32'h0000_004a);
        repeat (9) wr(MRRX_STACK_OFF, 32'h0000_0055);
        rdchk("stack full", MRRX_STACK_OFF, 32'h0000_8055);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'hf;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_load_store_nop();
        t_move();
        t_rotate();
        t_return();
        t_refused();
        tally_and_finish();
    end
endmodule

`default_nettype wire
